/* verilog/ibr_consts.svh */
// Offsets, field positions, reset words and timing counts of the bus register group.
// Included by the package and by the register bank; definitions only.
`ifndef IBR_CONSTS_SVH
`define IBR_CONSTS_SVH

// Register offsets within the register window
`define IBR_OFS_BUS_CTL 16'h0116
`define IBR_OFS_TEST_CTL 16'h0118
`define IBR_OFS_BID_ST 16'h0138
`define IBR_OFS_REFLECT 16'h013c

// Reset words; the low six bits are each register's fixed number
`define IBR_RST_BUS_CTL 16'h0017
`define IBR_RST_TEST_CTL 16'h0019
`define IBR_RST_BID_ST 16'h0018
`define IBR_RST_REFLECT 16'h001c
`define IBR_ID_MASK 16'h003f

// Writable bits of the two control registers
`define IBR_BUS_CTL_WMASK 16'hbf00
`define IBR_TEST_CTL_WMASK 16'h4e80

// Bus control field positions
`define IBR_B_FLUSH 6
`define IBR_B_EARLY_REL 8
`define IBR_B_INT_DECODE 9
`define IBR_B_MEM_PERMIT 10
`define IBR_B_BURST_LIM 11
`define IBR_B_WAIT_DIS 12
`define IBR_B_BUF_SIZE 13
`define IBR_B_IRQ_PERMIT 15

// Test control field positions
`define IBR_B_LT_OVR 7
`define IBR_B_CODEC_LOOP 9
`define IBR_B_AUI_LOOP 10
`define IBR_B_BACKOFF_BYP 11
`define IBR_B_FDX 14

// Bid status field positions
`define IBR_B_BID_ERR 7
`define IBR_B_SPACE_NOW 8

// Frame length limits in bytes
`define IBR_MAX_LEN_CRC 11'd1514
`define IBR_MAX_LEN_ANY 11'd1518

// Timing: clock period, burst and gap times in ns
`define IBR_CLK_NS 50
`define IBR_BURST_NS 28000
`define IBR_GAP_NS 1300
// Longest time rounds down, least time rounds up
`define IBR_BURST_CYC (`IBR_BURST_NS / `IBR_CLK_NS)
`define IBR_GAP_CYC ((`IBR_GAP_NS + `IBR_CLK_NS - 1) / `IBR_CLK_NS)

// Receive DMA buffer sizes in bytes, minus one, as wrap masks
`define IBR_BUF_MASK_16K 16'h3fff
`define IBR_BUF_MASK_64K 16'hffff

`endif

/* verilog/ibr_pkg.sv */
// Types shared by the bus register group and its bench.
// Assumes ibr_consts.svh holds every number.
`include "ibr_consts.svh"

package ibr_pkg;

   // One register-port access
   typedef struct packed {
      logic rd;
      logic wr;
      logic [1:0] be;
      logic [15:0] addr;
      logic [15:0] wdata;
   } ibr_reg_req_s;

   // Receive DMA request sequencer
   typedef enum logic [1:0] {
      IBR_DMA_IDLE = 2'b00,
      IBR_DMA_REQ = 2'b01,
      IBR_DMA_GAP = 2'b11,
      IBR_DMA_SGL = 2'b10
   } ibr_dma_state_e;

endpackage

/* verilog/ibr_bus_regs.sv */
// Bus interface and diagnostic control registers of a 10 Mb/s Ethernet controller.
// Assumes all inputs synchronous to clk_sys_i (20 MHz); the MAC, transmit
// command path and EEPROM loader sit outside and talk over plain ports.
`timescale 1ns/1ps
`include "ibr_consts.svh"

module ibr_bus_regs #(
   parameter int BURST_CYC = `IBR_BURST_CYC,
   parameter int GAP_CYC = `IBR_GAP_CYC
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Register port
   input ibr_pkg::ibr_reg_req_s reg_req_i,
   output logic [15:0] reg_rdata_o,
   // EEPROM loader override
   input wire logic eeprom_load_i,
   input wire logic [15:0] eeprom_bus_ctl_i,
   input wire logic [15:0] eeprom_test_ctl_i,
   // Receive DMA
   input wire logic rx_dma_ready_i,
   input wire logic rx_frame_last_i,
   input wire logic dma_ack_in_i,
   input wire logic ior_n_i,
   output logic dma_request_out_o,
   output logic rx_flush_o,
   output logic [15:0] rx_dma_offset_o,
   // Memory decode and wait line
   input wire logic chip_select_in_n_i,
   input wire logic [7:0] sa_hi_i,
   input wire logic [7:0] mem_base_i,
   input wire logic mem_mode_i,
   input wire logic io_read_i,
   input wire logic mem_read_i,
   input wire logic wait_req_i,
   output logic memcs16_n_o,
   output logic memcs16_oe_n_o,
   output logic mem_access_ok_o,
   output logic iochrdy_o,
   output logic iochrdy_oe_n_o,
   // Interrupt
   input wire logic irq_event_i,
   output logic irq_o,
   // Transmit bid
   input wire logic tx_bid_i,
   input wire logic [10:0] tx_len_i,
   input wire logic crc_append_suppress_i,
   input wire logic tx_space_event_i,
   output logic tx_bid_accept_o,
   output logic tx_crc_append_o,
   // Line and diagnostics
   input wire logic link_good_i,
   output logic pkt_path_enable_o,
   output logic codec_loopback_o,
   output logic attachment_port_loopback_o,
   output logic backoff_bypass_o,
   output logic full_duplex_select_o,
   // Reflectometer events
   input wire logic aui_tx_start_i,
   input wire logic aui_collision_i,
   input wire logic aui_carrier_loss_i
);
   import ibr_pkg::*;

   logic [15:0] bus_ctl_q, bus_ctl_d;
   logic [15:0] test_ctl_q, test_ctl_d;
   logic tx_bid_error_q;
   logic tx_space_now_q;
   logic [9:0] reflect_delay_count_q;
   logic reflect_run_q;
   logic tick_10m_q;
   logic ior_n_q;
   ibr_dma_state_e dma_state_q, dma_state_d;
   logic [9:0] burst_cnt_q;
   logic [4:0] gap_cnt_q;
   logic [15:0] offset_q;

   // Address decode
   wire sel_bus_ctl = (reg_req_i.addr == `IBR_OFS_BUS_CTL);
   wire sel_test_ctl = (reg_req_i.addr == `IBR_OFS_TEST_CTL);
   wire sel_bid_st = (reg_req_i.addr == `IBR_OFS_BID_ST);
   wire sel_reflect = (reg_req_i.addr == `IBR_OFS_REFLECT);
   wire [15:0] be_mask = {{8{reg_req_i.be[1]}}, {8{reg_req_i.be[0]}}};

   wire [15:0] bus_wmask = be_mask & `IBR_BUS_CTL_WMASK;
   wire [15:0] test_wmask = be_mask & `IBR_TEST_CTL_WMASK;

   wire flush = reg_req_i.wr & sel_bus_ctl & reg_req_i.be[0] &
                reg_req_i.wdata[`IBR_B_FLUSH];

   // Control bits
   wire early_rel = bus_ctl_q[`IBR_B_EARLY_REL];
   wire int_decode = bus_ctl_q[`IBR_B_INT_DECODE];
   wire mem_permit = bus_ctl_q[`IBR_B_MEM_PERMIT];
   wire burst_lim = bus_ctl_q[`IBR_B_BURST_LIM];
   wire wait_dis = bus_ctl_q[`IBR_B_WAIT_DIS];
   wire buf_64k = bus_ctl_q[`IBR_B_BUF_SIZE];
   wire irq_permit = bus_ctl_q[`IBR_B_IRQ_PERMIT];

   wire [15:0] rd_bus_ctl = (bus_ctl_q & ~`IBR_ID_MASK) | `IBR_RST_BUS_CTL;
   wire [15:0] rd_test_ctl = (test_ctl_q & ~`IBR_ID_MASK) | `IBR_RST_TEST_CTL;
   wire [15:0] rd_bid_st = `IBR_RST_BID_ST |
                           (16'(tx_bid_error_q) << `IBR_B_BID_ERR) |
                           (16'(tx_space_now_q) << `IBR_B_SPACE_NOW);
   wire [15:0] rd_reflect = {reflect_delay_count_q, 6'h1c};

   // Read selection; unmapped reads return zero
   wire [15:0] rd_word = sel_bus_ctl ? rd_bus_ctl :
                         sel_test_ctl ? rd_test_ctl :
                         sel_bid_st ? rd_bid_st :
                         sel_reflect ? rd_reflect : 16'h0000;

   // Control register next values; EEPROM load beats a register write
   always_comb begin
      bus_ctl_d = bus_ctl_q;
      test_ctl_d = test_ctl_q;
      if (eeprom_load_i) begin
         bus_ctl_d = eeprom_bus_ctl_i & `IBR_BUS_CTL_WMASK;
         test_ctl_d = eeprom_test_ctl_i & `IBR_TEST_CTL_WMASK;
      end else if (reg_req_i.wr) begin
         if (sel_bus_ctl) begin
            bus_ctl_d = (bus_ctl_q & ~bus_wmask) | (reg_req_i.wdata & bus_wmask);
         end
         if (sel_test_ctl) begin
            test_ctl_d = (test_ctl_q & ~test_wmask) | (reg_req_i.wdata & test_wmask);
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         bus_ctl_q <= `IBR_RST_BUS_CTL & `IBR_BUS_CTL_WMASK;
         test_ctl_q <= `IBR_RST_TEST_CTL & `IBR_TEST_CTL_WMASK;
         reg_rdata_o <= 16'h0000;
      end else begin
         bus_ctl_q <= bus_ctl_d;
         test_ctl_q <= test_ctl_d;
         reg_rdata_o <= reg_req_i.rd ? rd_word : 16'h0000;
      end
   end

   // Read-strobe edges for the DMA sequencer
   wire ior_fall = ior_n_q & ~ior_n_i;
   wire ior_rise = ~ior_n_q & ior_n_i;
   wire xfer = dma_ack_in_i & ior_fall;

   wire [15:0] wrap_mask = buf_64k ? `IBR_BUF_MASK_64K : `IBR_BUF_MASK_16K;
   wire [15:0] offset_inc = (offset_q + 16'h0002) & wrap_mask;
   wire burst_done = burst_lim & (burst_cnt_q >= 10'(BURST_CYC - 1));

   // DMA request sequencer
   always_comb begin
      dma_state_d = dma_state_q;
      case (dma_state_q)
         IBR_DMA_IDLE: begin
            if (rx_dma_ready_i) begin
               dma_state_d = IBR_DMA_REQ;
            end
         end
         IBR_DMA_REQ: begin
            if (burst_done) begin
               dma_state_d = IBR_DMA_GAP;
            end else if (early_rel & xfer) begin
               dma_state_d = IBR_DMA_SGL;
            end else if (!early_rel & dma_ack_in_i & ior_rise & rx_frame_last_i) begin
               dma_state_d = IBR_DMA_IDLE;
            end
         end
         IBR_DMA_GAP: begin
            if (gap_cnt_q >= 5'(GAP_CYC - 1)) begin
               dma_state_d = IBR_DMA_IDLE;
            end
         end
         IBR_DMA_SGL: begin
            // Wait for the strobe to end before asking again
            if (ior_rise) begin
               dma_state_d = IBR_DMA_IDLE;
            end
         end
         default: dma_state_d = IBR_DMA_IDLE;
      endcase
      if (flush) begin
         dma_state_d = IBR_DMA_IDLE;
      end
   end

   // Sequencer state, counters and offset pointer
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dma_state_q <= IBR_DMA_IDLE;
         burst_cnt_q <= 10'h000;
         gap_cnt_q <= 5'h00;
         offset_q <= 16'h0000;
         ior_n_q <= 1'b1;
      end else begin
         dma_state_q <= dma_state_d;
         ior_n_q <= ior_n_i;
         burst_cnt_q <= (dma_state_q == IBR_DMA_REQ) ? burst_cnt_q + 10'h001 : 10'h000;
         gap_cnt_q <= (dma_state_q == IBR_DMA_GAP) ? gap_cnt_q + 5'h01 : 5'h00;
         if (flush) begin
            offset_q <= 16'h0000;
         end else if (xfer) begin
            offset_q <= offset_inc;
         end
      end
   end

   // DMA outputs; request registered from next state so it drops in the strobe-fall cycle
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dma_request_out_o <= 1'b0;
         rx_flush_o <= 1'b0;
         rx_dma_offset_o <= 16'h0000;
      end else begin
         dma_request_out_o <= (dma_state_d == IBR_DMA_REQ);
         rx_flush_o <= flush;
         rx_dma_offset_o <= flush ? 16'h0000 : (xfer ? offset_inc : offset_q);
      end
   end

   wire addr_hit = int_decode ? (sa_hi_i == mem_base_i) : 1'b1;
   wire cs16_low = ~chip_select_in_n_i & addr_hit;
   wire cs16_drive = mem_mode_i & mem_permit;
   wire wait_low = ~wait_dis & wait_req_i & (io_read_i | mem_read_i);

   // Bus pin stage; enables are active low
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         memcs16_n_o <= 1'b1;
         memcs16_oe_n_o <= 1'b1;
         mem_access_ok_o <= 1'b0;
         iochrdy_o <= 1'b0;
         iochrdy_oe_n_o <= 1'b1;
         irq_o <= 1'b0;
      end else begin
         memcs16_n_o <= ~(cs16_drive & cs16_low);
         memcs16_oe_n_o <= ~cs16_drive;
         mem_access_ok_o <= mem_permit;
         iochrdy_o <= 1'b0;
         iochrdy_oe_n_o <= ~wait_low;
         irq_o <= irq_event_i & irq_permit;
      end
   end

   wire len_bad = (tx_len_i > `IBR_MAX_LEN_ANY) |
                  (!crc_append_suppress_i & (tx_len_i > `IBR_MAX_LEN_CRC));

   // Transmit bid; error sticks until a later bid is accepted
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_bid_error_q <= 1'b0;
         tx_space_now_q <= 1'b0;
         tx_bid_accept_o <= 1'b0;
         tx_crc_append_o <= 1'b0;
      end else begin
         if (tx_bid_i) begin
            tx_bid_error_q <= len_bad;
         end
         tx_space_now_q <= tx_space_event_i;
         tx_bid_accept_o <= tx_bid_i & ~len_bad;
         if (tx_bid_i & ~len_bad) begin
            tx_crc_append_o <= ~crc_append_suppress_i;
         end
      end
   end

   // Diagnostic mode outputs
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pkt_path_enable_o <= 1'b0;
         codec_loopback_o <= 1'b0;
         attachment_port_loopback_o <= 1'b0;
         backoff_bypass_o <= 1'b0;
         full_duplex_select_o <= 1'b0;
      end else begin
         pkt_path_enable_o <= link_good_i | test_ctl_q[`IBR_B_LT_OVR];
         codec_loopback_o <= test_ctl_q[`IBR_B_CODEC_LOOP];
         attachment_port_loopback_o <= test_ctl_q[`IBR_B_AUI_LOOP];
         backoff_bypass_o <= test_ctl_q[`IBR_B_BACKOFF_BYP];
         full_duplex_select_o <= test_ctl_q[`IBR_B_FDX];
      end
   end

   // reflectometer run window and 10 MHz tick
   wire reflect_stop = aui_collision_i | aui_carrier_loss_i;
   wire reflect_rd = reg_req_i.rd & sel_reflect;
   wire reflect_inc = reflect_run_q & tick_10m_q & (reflect_delay_count_q != 10'h3ff);

   // Counter saturates; a read clears it, but a tick in the same cycle still counts
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reflect_run_q <= 1'b0;
         tick_10m_q <= 1'b0;
         reflect_delay_count_q <= 10'h000;
      end else begin
         tick_10m_q <= reflect_run_q ? ~tick_10m_q : 1'b0;
         if (reflect_stop) begin
            reflect_run_q <= 1'b0;
         end else if (aui_tx_start_i) begin
            reflect_run_q <= 1'b1;
         end
         if (reflect_rd) begin
            reflect_delay_count_q <= reflect_inc ? 10'h001 : 10'h000;
         end else if (reflect_inc) begin
            reflect_delay_count_q <= reflect_delay_count_q + 10'h001;
         end
      end
   end

endmodule

/* dv/ibr_bus_regs_chk.sv */
// Port-level property checker for the bus register group.
// Assumes one clock domain; attached to every ibr_bus_regs by the bind below.
`timescale 1ns/1ps
module ibr_bus_regs_chk (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Register port
   input ibr_pkg::ibr_reg_req_s reg_req_i,
   input wire logic [15:0] reg_rdata_o,
   // Memory decode
   input wire logic chip_select_in_n_i,
   input wire logic mem_mode_i,
   input wire logic memcs16_n_o,
   input wire logic memcs16_oe_n_o,
   // Interrupt and bid
   input wire logic irq_event_i,
   input wire logic irq_o,
   input wire logic tx_bid_i,
   input wire logic [10:0] tx_len_i,
   input wire logic crc_append_suppress_i,
   input wire logic tx_bid_accept_o,
   // Receive DMA
   input wire logic rx_flush_o,
   input wire logic [15:0] rx_dma_offset_o,
   input wire logic dma_request_out_o
);
   import ibr_pkg::*;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   // Read data only in the cycle after a read
   rd_quiet_a: assert property (
      !$past(reg_req_i.rd) |-> reg_rdata_o == 16'h0000) else $error("read data without read");
   id_bus_a: assert property (
      $past(reg_req_i.rd && reg_req_i.addr == 16'h0116) |-> reg_rdata_o[5:0] == 6'h17)
      else $error("bus control number wrong");
   id_test_a: assert property (
      $past(reg_req_i.rd && reg_req_i.addr == 16'h0118) |-> reg_rdata_o[5:0] == 6'h19)
      else $error("test control number wrong");
   irq_gate_a: assert property (
      irq_o |-> $past(irq_event_i)) else $error("interrupt without event");
   memcs_oe_a: assert property (
      !memcs16_oe_n_o |-> $past(mem_mode_i)) else $error("memcs16 driven outside memory mode");
   memcs_sel_a: assert property (
      !memcs16_n_o |-> $past(!chip_select_in_n_i)) else $error("memcs16 low without select");
   bid_len_a: assert property (
      tx_bid_accept_o |-> $past(tx_bid_i && (tx_len_i <= (crc_append_suppress_i ?
      11'd1518 : 11'd1514)))) else $error("oversize bid accepted");
   bid_refuse_a: assert property (
      tx_bid_i && tx_len_i > 11'd1518 |=> !tx_bid_accept_o) else $error("long bid accepted");
   flush_done_a: assert property (
      rx_flush_o |-> rx_dma_offset_o == 16'h0000 && !dma_request_out_o)
      else $error("flush left offset or request");
   // Main scenarios reached
   cover property (rx_flush_o);
   cover property (tx_bid_accept_o);
   cover property (!memcs16_n_o ##1 memcs16_n_o);
endmodule

bind ibr_bus_regs ibr_bus_regs_chk u_ibr_bus_regs_chk (.*);

/* dv/ibr_host_dma.sv */
// Behavioural system DMA controller answering the receive DMA request.
// Same clock as the device; ack and strobe change just after rising edges.
`timescale 1ns/1ps
module ibr_host_dma (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   // Handshake
   input wire logic dma_request_i,
   input wire logic slow_i,
   output logic dma_ack_o,
   output logic ior_n_o
);
   int cnt;
   // Grant after a short or long latency, then one read strobe every fourth cycle
   // ack held until request drops
   always @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt <= 0;
         dma_ack_o <= 1'b0;
         ior_n_o <= 1'b1;
      end else if (!dma_ack_o) begin
         cnt <= dma_request_i ? cnt + 1 : 0;
         if (dma_request_i && cnt >= (slow_i ? 4 : 1)) begin
            dma_ack_o <= 1'b1;
            cnt <= 0;
         end
      end else if (!ior_n_o) begin
         ior_n_o <= 1'b1;
      end else if (!dma_request_i) begin
         dma_ack_o <= 1'b0;
      end else begin
         cnt <= (cnt == 2) ? 0 : cnt + 1;
         ior_n_o <= (cnt != 2);
      end
   end
endmodule

/* dv/tb_ibr_bus_regs.sv */
// Self-checking bench for the bus register group.
// Bench signals carry the port names; a DMA controller model answers requests.
`timescale 1ns/1ps
module tb_ibr_bus_regs;
   import ibr_pkg::*;
   // Design ports; the bench-driven inputs given values at time zero
   logic clk_sys_i = 1'b0, resetn_i = 1'b0, eeprom_load_i = 1'b0, rx_dma_ready_i = 1'b0;
   ibr_reg_req_s reg_req_i = '0;
   logic [15:0] reg_rdata_o, rx_dma_offset_o, eeprom_bus_ctl_i = 16'h0000;
   logic [15:0] eeprom_test_ctl_i = 16'h0000;
   logic rx_frame_last_i = 1'b0, dma_ack_in_i, ior_n_i, dma_request_out_o, rx_flush_o;
   logic chip_select_in_n_i = 1'b1, mem_mode_i = 1'b0, io_read_i = 1'b0, mem_read_i = 1'b0;
   logic [7:0] sa_hi_i = 8'h00, mem_base_i = 8'h0d;
   logic wait_req_i = 1'b0, memcs16_n_o, memcs16_oe_n_o, mem_access_ok_o, iochrdy_o;
   logic iochrdy_oe_n_o, irq_event_i = 1'b0, irq_o, tx_bid_i = 1'b0, tx_bid_accept_o;
   logic [10:0] tx_len_i = 11'h000;
   logic crc_append_suppress_i = 1'b0, tx_space_event_i = 1'b0, tx_crc_append_o;
   logic link_good_i = 1'b1, pkt_path_enable_o, codec_loopback_o, attachment_port_loopback_o;
   logic backoff_bypass_o, full_duplex_select_o, aui_tx_start_i = 1'b0;
   logic aui_collision_i = 1'b0, aui_carrier_loss_i = 1'b0, slow = 1'b0;
   int err_count = 0, checks = 0, cyc = 0;

   ibr_bus_regs #(.BURST_CYC(8), .GAP_CYC(3)) u_ibr_bus_regs (.*);
   ibr_host_dma u_ibr_host_dma (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .dma_request_i(dma_request_out_o), .slow_i(slow), .dma_ack_o(dma_ack_in_i),
      .ior_n_o(ior_n_i));

   // 20 MHz clock
   initial begin
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   task automatic close_out();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Levels only; pulses are looked at in their own cycle
   task automatic settle();
      repeat (2) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_sys_i) reg_req_i <= '{rd: 1'b0, wr: 1'b1, be: 2'b11, addr: a, wdata: d};
      @(posedge clk_sys_i) reg_req_i.wr <= 1'b0;
   endtask

   // Read data stands one cycle, so it is captured right after the taking edge
   task automatic rd(input logic [15:0] a);
      @(posedge clk_sys_i) reg_req_i <= '{rd: 1'b1, wr: 1'b0, be: 2'b11, addr: a, wdata: 16'h0000};
      @(posedge clk_sys_i) reg_req_i.rd <= 1'b0;
      #1;
   endtask

   task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
      rd(a);
      cmp(reg_rdata_o, exp);
   endtask

   // Bounded wait on the DMA request level
   // Judged where found: a drop may stand one cycle only while ready stays high
   task automatic await_req(input logic v);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys_i);
         n++;
      end while (dma_request_out_o !== v && n < 100);
      cmp({15'h0, dma_request_out_o}, {15'h0, v});
   endtask

   task automatic t_reset();
      rdc(16'h0116, 16'h0017);
      rdc(16'h0118, 16'h0019);
      rdc(16'h0138, 16'h0018);
      rdc(16'h013c, 16'h001c);
      rdc(16'h0120, 16'h0000);
      @(posedge clk_sys_i) eeprom_bus_ctl_i <= 16'h0800;
      eeprom_load_i <= 1'b1;
      @(posedge clk_sys_i) eeprom_load_i <= 1'b0;
      rdc(16'h0116, 16'h0817);
   endtask

   task automatic t_test_ctl();
      @(posedge clk_sys_i) link_good_i <= 1'b0;
      wr(16'h0118, 16'hffff);
      rdc(16'h0118, 16'h4e99);
      settle();
      cmp({11'h0, pkt_path_enable_o, codec_loopback_o, attachment_port_loopback_o,
         backoff_bypass_o, full_duplex_select_o}, 16'h001f);
      wr(16'h0118, 16'h0000);
      settle();
      cmp({15'h0, pkt_path_enable_o | full_duplex_select_o}, 16'h0000);
      @(posedge clk_sys_i) link_good_i <= 1'b1;
      settle();
      cmp({15'h0, pkt_path_enable_o}, 16'h0001);
      wr(16'h0138, 16'hffff);
      rdc(16'h0138, 16'h0018);
   endtask

   task automatic t_irq();
      @(posedge clk_sys_i) irq_event_i <= 1'b1;
      settle();
      cmp({15'h0, irq_o}, 16'h0000);
      wr(16'h0116, 16'h8000);
      settle();
      cmp({15'h0, irq_o}, 16'h0001);
      wr(16'h0116, 16'h0000);
      settle();
      cmp({15'h0, irq_o}, 16'h0000);
   endtask

   // Order of bits: select, enable, access allowed, wait enable
   task automatic t_mem();
      wr(16'h0116, 16'h0600);
      @(posedge clk_sys_i) mem_mode_i <= 1'b1;
      chip_select_in_n_i <= 1'b0;
      sa_hi_i <= 8'h0d;
      io_read_i <= 1'b1;
      wait_req_i <= 1'b1;
      settle();
      cmp({12'h0, memcs16_n_o, memcs16_oe_n_o, mem_access_ok_o, iochrdy_oe_n_o}, 16'h0002);
      @(posedge clk_sys_i) sa_hi_i <= 8'h0e;
      io_read_i <= 1'b0;
      settle();
      cmp({12'h0, memcs16_n_o, memcs16_oe_n_o, mem_access_ok_o, iochrdy_oe_n_o}, 16'h000b);
      wr(16'h0116, 16'h0400);
      settle();
      cmp({12'h0, memcs16_n_o, memcs16_oe_n_o, mem_access_ok_o, iochrdy_oe_n_o}, 16'h0003);
      wr(16'h0116, 16'h0000);
      settle();
      cmp({12'h0, memcs16_n_o, memcs16_oe_n_o, mem_access_ok_o, iochrdy_oe_n_o}, 16'h000d);
      // Wait disable floats the line even on a stretched read; it never drives high
      @(posedge clk_sys_i) io_read_i <= 1'b1;
      wr(16'h0116, 16'h1000);
      settle();
      cmp({14'h0, iochrdy_o, iochrdy_oe_n_o}, 16'h0001);
      wr(16'h0116, 16'h0000);
      settle();
      cmp({14'h0, iochrdy_o, iochrdy_oe_n_o}, 16'h0000);
      @(posedge clk_sys_i) chip_select_in_n_i <= 1'b1;
      mem_mode_i <= 1'b0;
      io_read_i <= 1'b0;
   endtask

   // Lengths at both limits, with and without CRC appending
   task automatic t_bid();
      logic [10:0] lens [5] = '{11'd1514, 11'd1515, 11'd1518, 11'd1519, 11'd60};
      logic [4:0] sup_v = 5'b01100;
      logic [4:0] acc_v = 5'b10101;
      @(posedge clk_sys_i) tx_space_event_i <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_sys_i) tx_bid_i <= 1'b1;
         tx_len_i <= lens[i];
         crc_append_suppress_i <= sup_v[i];
         @(posedge clk_sys_i) tx_bid_i <= 1'b0;
         #1 cmp({15'h0, tx_bid_accept_o}, {15'h0, acc_v[i]});
         if (acc_v[i]) cmp({15'h0, tx_crc_append_o}, {15'h0, !sup_v[i]});
         rdc(16'h0138, {7'h0, 1'b1, !acc_v[i], 1'b0, 6'h18});
      end
   endtask

   task automatic t_dma();
      @(posedge clk_sys_i) rx_dma_ready_i <= 1'b1;
      rx_frame_last_i <= 1'b1;
      await_req(1'b1);
      await_req(1'b0);
      cmp(rx_dma_offset_o, 16'h0002);
      @(posedge clk_sys_i) rx_dma_ready_i <= 1'b0;
      wr(16'h0116, 16'h0040);
      @(negedge clk_sys_i) cmp({14'h0, rx_flush_o, dma_request_out_o}, 16'h0002);
      cmp(rx_dma_offset_o, 16'h0000);
      rdc(16'h0116, 16'h0017);
      // Slow grant, early release, frame not yet complete
      @(posedge clk_sys_i) slow <= 1'b1;
      wr(16'h0116, 16'h0100);
      @(posedge clk_sys_i) rx_dma_ready_i <= 1'b1;
      rx_frame_last_i <= 1'b0;
      await_req(1'b1);
      await_req(1'b0);
      cmp(rx_dma_offset_o, 16'h0002);
      @(posedge clk_sys_i) rx_dma_ready_i <= 1'b0;
      // Burst limit: request drops for the gap, then comes back by itself
      wr(16'h0116, 16'h0800);
      @(posedge clk_sys_i) rx_dma_ready_i <= 1'b1;
      await_req(1'b1);
      await_req(1'b0);
      await_req(1'b1);
      @(posedge clk_sys_i) rx_dma_ready_i <= 1'b0;
      // Flush also clears the burst bit; ready is low, so the sequencer stays idle afterwards
      wr(16'h0116, 16'h0040);
      @(negedge clk_sys_i) cmp({15'h0, dma_request_out_o}, 16'h0000);
   endtask

   task automatic t_tdr();
      @(posedge clk_sys_i) aui_tx_start_i <= 1'b1;
      @(posedge clk_sys_i) aui_tx_start_i <= 1'b0;
      repeat (19) @(posedge clk_sys_i);
      aui_collision_i <= 1'b1;
      @(posedge clk_sys_i) aui_collision_i <= 1'b0;
      rd(16'h013c);
      cmp({15'h0, reg_rdata_o[15:6] >= 10'd9 && reg_rdata_o[15:6] <= 10'd11}, 16'h0001);
      rdc(16'h013c, 16'h001c);
   endtask

   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end

   initial begin
      repeat (10) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      t_reset();
      t_test_ctl();
      t_irq();
      t_mem();
      t_bid();
      t_dma();
      t_tdr();
      close_out();
   end
endmodule
